// *** dv/bsw_sleep_wake_monitor.sv ***
// port-level assertion checker for the sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
module bsw_sleep_wake_monitor
	import bsw_pkg::*;
#(
	parameter longint unsigned LONG_CYC = BSW_LONG_CYC
) (
	// clock, reset and inputs
	input wire logic                  mclk,
	input wire logic                  arst_n,
	input wire logic                  cmd_valid,
	input wire logic [2:0]            cmd_code,
	input wire logic                  cfg_restore_last,
	input wire logic                  cfg_restore_on,
	input wire logic                  fan_loop_en,
	input wire logic                  ac_ok,
	input wire logic                  pwr_btn,
	// outputs watched
	input wire logic [BSW_FANS-1:0]   fan_pwm,
	input wire logic                  psu_on,
	input wire logic                  cpu_pwr_en,
	input wire logic [5:0]            state_out,
	input wire logic [BSW_WK_NUM-1:0] wake_pend
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	logic        run;
	logic [31:0] btn_cnt_reg;
	logic [31:0] btn_cnt_next;
	assign run = state_out inside {BSW_S0, BSW_S1};
	// held-button length, counted on the raw pin so sync lag is covered by slack
	always_comb btn_cnt_next = (pwr_btn && ac_ok) ? btn_cnt_reg + 32'h1 : 32'h0;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			btn_cnt_reg <= 32'h0;
		else
			btn_cnt_reg <= btn_cnt_next;
	end
	a_cmd_moves: assert property (
		cmd_valid && cmd_code inside {[3'h1:3'h5]} && ac_ok && $past(ac_ok) && !pwr_btn
		&& state_out != BSW_OFF && wake_pend == 0 |=> state_out == 6'h01 << $past(cmd_code))
		else $error("command did not set state");
	a_hold_state: assert property (
		ac_ok && $past(ac_ok) && !cmd_valid && wake_pend == 0 && !pwr_btn && !$past(pwr_btn)
		&& !$past(pwr_btn, 2) && state_out != BSW_OFF |=> $stable(state_out))
		else $error("state moved without cause");
	a_psu_run: assert property (psu_on == run && cpu_pwr_en == run)
		else $error("supply enable wrong for state");
	a_fan_stop: assert property ((!run)[*3] |-> fan_pwm == 3'h0)
		else $error("fans driven while asleep");
	a_fan_full: assert property ((run && !fan_loop_en)[*3] |-> fan_pwm == 3'h7)
		else $error("fans not full on");
	a_shallow_only: assert property (
		state_out inside {BSW_S4, BSW_S5} && $stable(state_out) |-> wake_pend[6:4] == 3'h0)
		else $error("shallow source latched in deep sleep");
	a_wake_s0: assert property (
		(wake_pend & 7'h7b) != 0 && ac_ok && !cmd_valid |=> state_out == BSW_S0)
		else $error("pending wake not served");
	a_s0_quiet: assert property (
		state_out == BSW_S0 && $past(state_out) == BSW_S0 |-> wake_pend == 0)
		else $error("wake latched while working");
	a_ac_off: assert property (!ac_ok |=> state_out == BSW_OFF && wake_pend == 0)
		else $error("mains loss not honoured");
	a_ac_restore: assert property (
		$rose(ac_ok) && !cfg_restore_last |=> state_out == (cfg_restore_on ? BSW_S0 : BSW_S5))
		else $error("restore setting ignored");
	a_long_press: assert property (btn_cnt_reg == LONG_CYC + 4 |-> state_out == BSW_S5)
		else $error("long press did not force off");
endmodule : bsw_sleep_wake_monitor
`default_nettype wire

// *** dv/bsw_sleep_wake_test.sv ***
// self-checking testbench for the sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
module bsw_sleep_wake_test;
	import bsw_pkg::*;
	typedef struct {logic [2:0] c; int s; bsw_state_e e;} bsw_row_s;
	localparam int LONG = 16;
	logic        mclk, arst_n, cmd_valid, cfg_deep_wake, cfg_restore_last, cfg_restore_on;
	logic        ac_ok, backup_ok, clr, psu_on, cpu_pwr_en, btn_sleep_req;
	logic [2:0]  cmd_code, tach, fan_pwm;
	logic [6:0]  evt, wk, wake_pend;
	logic [5:0]  state_out;
	logic [47:0] tcnt;
	logic        loop_en, seen;
	int          hi;
	int          n_errors = 0;
	int          n_checks = 0;
	// command before, source, state expected after the wake attempt
	bsw_row_s rows[14] = '{'{2,0,BSW_S0}, '{3,1,BSW_S0}, '{4,3,BSW_S0}, '{5,3,BSW_S0},
		'{2,4,BSW_S0}, '{3,5,BSW_S0}, '{3,6,BSW_S0}, '{4,4,BSW_S4}, '{4,5,BSW_S4},
		'{5,6,BSW_S5}, '{5,0,BSW_S5}, '{4,0,BSW_S0}, '{1,3,BSW_S0}, '{4,2,BSW_S0}};
	bsw_src_model u_src (.mclk(mclk), .evt(evt), .clr(clr), .psu_on(psu_on), .wk(wk));
	bsw_sleep_wake #(.LONG_CYC(LONG)) dut (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cfg_deep_wake(cfg_deep_wake), .cfg_restore_last(cfg_restore_last),
		.cfg_restore_on(cfg_restore_on), .fan_loop_en(loop_en), .fan_speed(8'h80), .ac_ok(ac_ok),
		.backup_ok(backup_ok), .wake_lan(wk[0]), .wake_pci(wk[1]), .pwr_btn(wk[2]),
		.wake_rtc(wk[3]), .wake_modem(wk[4]), .wake_kbm(wk[5]), .wake_usb(wk[6]),
		.fan_tach(tach), .fan_pwm(fan_pwm), .fan_tach_count(tcnt), .psu_on(psu_on),
		.cpu_pwr_en(cpu_pwr_en), .state_out(state_out), .wake_pend(wake_pend),
		.btn_sleep_req(btn_sleep_req));
	task automatic chk(string nm, logic [47:0] got, logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// one-cycle command strobe; clr also drops any source the board ignored
	task automatic cmd(logic [2:0] code);
		@(negedge mclk);
		{cmd_valid, cmd_code, clr} = {1'b1, code, 1'b1};
		@(negedge mclk);
		{cmd_valid, clr} = 2'b00;
		repeat (2) @(negedge mclk);
	endtask : cmd
	task automatic pulse(int s, int n);
		evt[s] = 1'b1;
		repeat (n) @(negedge mclk);
		evt[s] = 1'b0;
		repeat (6) @(negedge mclk);
	endtask : pulse
	task automatic ac_cycle(bsw_state_e exp);
		{ac_ok, backup_ok} = 2'b00;
		pulse(BSW_WK_RTC, 1);
		chk("off", state_out, BSW_OFF);
		chk("pend", wake_pend, 7'h00);
		{ac_ok, backup_ok} = 2'b11;
		repeat (3) @(negedge mclk);
		chk("restore", state_out, exp);
	endtask : ac_cycle
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// watchdog: the whole run needs well under 1500 cycles
	initial begin
		repeat (4000) @(posedge mclk);
		n_errors++;
		results();
	end
	initial begin
		{cmd_valid, cfg_deep_wake, cfg_restore_last, cfg_restore_on, arst_n, loop_en} = 6'h00;
		// mains and backup present from the start, sources quiet
		{ac_ok, backup_ok, clr, cmd_code, evt, tach} = 16'he000;
		repeat (2) @(negedge mclk);
		{arst_n, clr} = 2'b10;
		repeat (3) @(negedge mclk);
		chk("rst state", state_out, BSW_S5);
		chk("rst psu", psu_on, 1'b0);
		$display("test reset done");
		foreach (rows[i]) begin
			cmd(rows[i].c);
			pulse(rows[i].s, 1);
			chk("state", state_out, rows[i].e);
			chk("fans", fan_pwm, (rows[i].e == BSW_S0) ? 3'h7 : 3'h0);
		end
		$display("test wake table done");
		cfg_deep_wake = 1'b1;
		cmd(BSW_CMD_S5);
		pulse(BSW_WK_PME, 1);
		chk("deep wake", state_out, BSW_S0);
		cfg_deep_wake = 1'b0;
		$display("test deep wake done");
		evt[BSW_WK_BTN] = 1'b1;
		repeat (LONG + 6) @(negedge mclk);
		chk("long press", state_out, BSW_S5);
		pulse(BSW_WK_BTN, 0);
		$display("test long press done");
		cfg_restore_last = 1'b1;
		cmd(BSW_CMD_S0);
		ac_cycle(BSW_S0);
		cmd(BSW_CMD_S5);
		ac_cycle(BSW_S5);
		{cfg_restore_last, cfg_restore_on} = 2'b01;
		ac_cycle(BSW_S0);
		$display("test mains loss done");
		repeat (3) begin
			tach = 3'h2;
			repeat (2) @(negedge mclk);
			tach = 3'h0;
			repeat (2) @(negedge mclk);
		end
		chk("tach", tcnt[31:16], 16'h0003);
		$display("test tach done");
		// short press in s0 only asks software for sleep
		seen = 1'b0;
		evt[BSW_WK_BTN] = 1'b1;
		repeat (2) @(negedge mclk);
		evt[BSW_WK_BTN] = 1'b0;
		repeat (6) begin
			@(negedge mclk);
			seen = seen | btn_sleep_req;
		end
		chk("sleep req", seen, 1'b1);
		chk("short press", state_out, BSW_S0);
		$display("test short press done");
		// closed loop at half duty: a free 8-bit phase gives 128 high of 256
		loop_en = 1'b1;
		hi = 0;
		repeat (2) @(negedge mclk);
		repeat (256) begin
			@(negedge mclk);
			hi = hi + int'(fan_pwm[0]);
		end
		chk("duty", hi, 128);
		loop_en = 1'b0;
		repeat (3) @(negedge mclk);
		chk("full on", fan_pwm, 3'h7);
		$display("test fan loop done");
		results();
	end
endmodule : bsw_sleep_wake_test
bind bsw_sleep_wake bsw_sleep_wake_monitor #(.LONG_CYC(LONG_CYC)) u_mon (.mclk, .arst_n,
	.cmd_valid, .cmd_code, .cfg_restore_last, .cfg_restore_on, .fan_loop_en, .ac_ok,
	.pwr_btn, .fan_pwm, .psu_on, .cpu_pwr_en, .state_out, .wake_pend);
`default_nettype wire

// *** dv/bsw_src_model.sv ***
// wake-source partner model feeding the sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
module bsw_src_model
	import bsw_pkg::*;
(
	// clock and bench control
	input  wire logic                  mclk,
	input  wire logic [BSW_WK_NUM-1:0] evt,
	input  wire logic                  clr,
	// board feedback
	input  wire logic                  psu_on,
	// wake lines
	output logic      [BSW_WK_NUM-1:0] wk
);
	initial wk = 7'h00;
	// a source keeps asking until the board is powered; the button follows the finger only
	always @(posedge mclk) begin
		wk <= evt | (wk & ((psu_on | clr) ? 7'h00 : 7'h7b));
	end
endmodule : bsw_src_model
`default_nettype wire

// *** include/bsw_fan_if.sv ***
// interface carrying fan control between the sequencer and the fan channel
`timescale 1ns/1ps
`default_nettype none
interface bsw_fan_if;
	import bsw_pkg::*;
	logic                 run;
	logic [BSW_SPD_W-1:0] speed;
	logic                 loop_en;
	modport ctl (output run, output speed, output loop_en);
	modport fan (input run, input speed, input loop_en);
endinterface : bsw_fan_if
`default_nettype wire

// *** include/bsw_pkg.sv ***
// package of states, codes and timing constants for the sleep/wake controller
package bsw_pkg;

	// one-hot sleep states
	typedef enum logic [5:0] {
		BSW_OFF = 6'h01,
		BSW_S0  = 6'h02,
		BSW_S1  = 6'h04,
		BSW_S3  = 6'h08,
		BSW_S4  = 6'h10,
		BSW_S5  = 6'h20
	} bsw_state_e;

	// software command codes
	localparam logic [2:0] BSW_CMD_NONE = 3'h0;
	localparam logic [2:0] BSW_CMD_S0   = 3'h1;
	localparam logic [2:0] BSW_CMD_S1   = 3'h2;
	localparam logic [2:0] BSW_CMD_S3   = 3'h3;
	localparam logic [2:0] BSW_CMD_S4   = 3'h4;
	localparam logic [2:0] BSW_CMD_S5   = 3'h5;

	// wake source bit positions
	localparam int BSW_WK_LAN  = 0;
	localparam int BSW_WK_PME  = 1;
	localparam int BSW_WK_BTN  = 2;
	localparam int BSW_WK_RTC  = 3;
	localparam int BSW_WK_MDM  = 4;
	localparam int BSW_WK_KBM  = 5;
	localparam int BSW_WK_USB  = 6;
	localparam int BSW_WK_NUM  = 7;

	// mask of sources that also wake from S4 and S5
	localparam logic [6:0] BSW_DEEP_SRC = 7'h0f;

	// fan channels and speed width
	localparam int BSW_FANS    = 3;
	localparam int BSW_SPD_W   = 8;
	localparam logic [7:0] BSW_SPD_FULL = 8'hff;

	// timing
	localparam int unsigned BSW_CLK_HZ       = 25000000;
	localparam int unsigned BSW_LONG_PRESS_S = 4;
	localparam longint unsigned BSW_LONG_CYC =
		longint'(BSW_LONG_PRESS_S) * longint'(BSW_CLK_HZ);
	localparam int BSW_PR_W = 27;

	// reset defaults
	localparam logic BSW_DEEP_WAKE_RST = 1'b0;
	localparam logic BSW_LAST_ON_RST   = 1'b0;

endpackage : bsw_pkg

// *** rtl/bsw_fan_chan.sv ***
// fan channels: pwm drive and tachometer pulse counting
`timescale 1ns/1ps
`default_nettype none
module bsw_fan_chan
	import bsw_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// control from the sequencer
	bsw_fan_if.fan                    ctl,
	// fan pins
	input  wire logic [BSW_FANS-1:0]  tach,
	output logic      [BSW_FANS-1:0]  fan_pwm,
	output logic [BSW_FANS*16-1:0]    tach_count
);
	logic [BSW_SPD_W-1:0]  ph_reg, ph_next;
	logic [BSW_FANS-1:0]   pwm_reg, pwm_next;
	logic [BSW_FANS-1:0]   tprev_reg, tprev_next;
	logic [BSW_FANS*16-1:0] cnt_reg, cnt_next;
	logic [BSW_SPD_W-1:0]  duty;

	// closed loop uses the requested speed, open loop runs full or off
	always_comb begin
		duty = ctl.loop_en ? ctl.speed : BSW_SPD_FULL;
		ph_next = ph_reg + 8'h01;
		tprev_next = tach;
		cnt_next = cnt_reg;
		for (int i = 0; i < BSW_FANS; i++) begin
			// off states force the drive low regardless of duty
			pwm_next[i] = ctl.run && (ph_reg < duty || duty == BSW_SPD_FULL);
			if (tach[i] && !tprev_reg[i])
				cnt_next[i*16 +: 16] = cnt_reg[i*16 +: 16] + 16'h0001;
		end
	end

	// registers only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph_reg    <= 8'h00;
			pwm_reg   <= 3'h0;
			tprev_reg <= 3'h0;
			cnt_reg   <= 48'h0;
		end else begin
			ph_reg    <= ph_next;
			pwm_reg   <= pwm_next;
			tprev_reg <= tprev_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign fan_pwm    = pwm_reg;
	assign tach_count = cnt_reg;

endmodule : bsw_fan_chan
`default_nettype wire

// *** rtl/bsw_sleep_wake.sv ***
// board sleep-state and wake-up sequencer
// Behaviour
// - state changes on a software command, a latched wake, a long press or ac loss/return; otherwise the state holds
// - lan, pci wake, button, rtc alarm wake from s1, s3, s4, s5
// - modem, keyboard/mouse, usb wake only from s1 and s3
// - lan and pci wake from s5 off after reset, on by setting
// - fans run in s0 and s1
// - fans stop when off or in s3, s4, s5
// - one tachometer input per fan, pulses counted
// - all fans share one closed-loop speed or full on/off control
// - power-off command drops non-standby rails, standby stays
// - after ac returns, restore the prior on or off state
// - a setting selects behaviour after ac restore
// - network wake accepted on pci wake line or on-board lan line
// - processor unpowered in s3, s4, s5; only wake logic on standby
// - without ac and no backup, no wake is processed
// - button under four seconds wakes the board or, in s0, requests sleep; over four seconds forces soft-off from s0, s1, s3, s4; from s5 it wakes on release
`timescale 1ns/1ps
`default_nettype none
module bsw_sleep_wake
	import bsw_pkg::*;
#(
	parameter longint unsigned LONG_CYC = BSW_LONG_CYC
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	// software commands and settings
	input  wire logic                 cmd_valid,
	input  wire logic [2:0]           cmd_code,
	input  wire logic                 cfg_deep_wake,
	input  wire logic                 cfg_restore_last,
	input  wire logic                 cfg_restore_on,
	// fan settings
	input  wire logic                 fan_loop_en,
	input  wire logic [BSW_SPD_W-1:0] fan_speed,
	// supply status
	input  wire logic                 ac_ok,
	input  wire logic                 backup_ok,
	// wake sources
	input  wire logic                 wake_lan,
	input  wire logic                 wake_pci,
	input  wire logic                 pwr_btn,
	input  wire logic                 wake_rtc,
	input  wire logic                 wake_modem,
	input  wire logic                 wake_kbm,
	input  wire logic                 wake_usb,
	// fans
	input  wire logic [BSW_FANS-1:0]  fan_tach,
	output logic      [BSW_FANS-1:0]  fan_pwm,
	output logic [BSW_FANS*16-1:0]    fan_tach_count,
	// power outputs and status
	output logic                      psu_on,
	output logic                      cpu_pwr_en,
	output logic [5:0]                state_out,
	output logic [BSW_WK_NUM-1:0]     wake_pend,
	output logic                      btn_sleep_req
);
	bsw_fan_if fan_bus ();

	logic rs1_reg, rs2_reg;
	logic rst_n;

	// reset release through two flops
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rs1_reg <= 1'b0;
			rs2_reg <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rs2_reg <= rs1_reg;
		end
	end
	assign rst_n = rs2_reg;

	// wake inputs are taken as synchronous; this stage aligns them
	logic [BSW_WK_NUM-1:0] raw;
	logic [BSW_WK_NUM-1:0] wsync_reg, wprev_reg;
	assign raw = {wake_usb, wake_kbm, wake_modem, wake_rtc, pwr_btn, wake_pci, wake_lan};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wsync_reg <= 7'h00;
			wprev_reg <= 7'h00;
		end else begin
			wsync_reg <= raw;
			wprev_reg <= wsync_reg;
		end
	end

	// allowed sources in a given state
	function automatic logic [BSW_WK_NUM-1:0] allowed(input bsw_state_e st, input logic deep);
		logic [BSW_WK_NUM-1:0] m;
		m = 7'h00;
		unique case (st)
			BSW_S1, BSW_S3: m = 7'h7f;
			BSW_S4: m = BSW_DEEP_SRC;
			BSW_S5: begin
				m = BSW_DEEP_SRC;
				if (!deep) begin
					m[BSW_WK_LAN] = 1'b0;
					m[BSW_WK_PME] = 1'b0;
				end
			end
			BSW_S0, BSW_OFF: m = 7'h00;
		endcase
		return m;
	endfunction : allowed

	bsw_state_e st_reg, st_next;
	logic [BSW_WK_NUM-1:0] pend_reg, pend_next;
	logic [BSW_PR_W-1:0] pr_reg, pr_next;
	logic long_reg, long_next;
	logic last_on_reg, last_on_next;
	logic ac_prev_reg, ac_prev_next;
	logic deep_reg, deep_next;
	logic sreq_reg, sreq_next;
	logic pwr_live;
	logic [BSW_WK_NUM-1:0] rise;
	logic btn_rel;

	assign pwr_live = ac_ok || backup_ok;
	assign rise     = wsync_reg & ~wprev_reg;
	assign btn_rel  = !wsync_reg[BSW_WK_BTN] && wprev_reg[BSW_WK_BTN];

	// next-state: commands, wake latch, button timing, ac restore
	always_comb begin
		st_next      = st_reg;
		pend_next    = pend_reg;
		pr_next      = pr_reg;
		long_next    = long_reg;
		last_on_next = last_on_reg;
		ac_prev_next = ac_ok;
		deep_next    = cfg_deep_wake;
		sreq_next    = 1'b0;

		// latch qualified wake edges while power is present
		if (pwr_live)
			pend_next = pend_reg | (rise & allowed(st_reg, deep_reg));

		// button hold timer
		if (wsync_reg[BSW_WK_BTN]) begin
			if (!long_reg && pr_reg != LONG_CYC[BSW_PR_W-1:0] - 27'h1)
				pr_next = pr_reg + 27'h1;
			else
				long_next = 1'b1;
		end else begin
			pr_next   = 27'h0;
			long_next = 1'b0;
		end

		if (!ac_ok) begin
			// everything unpowered; remember only whether we were on
			st_next = BSW_OFF;
			pend_next = 7'h00;
		end else if (!ac_prev_reg) begin
			// ac just returned
			if (cfg_restore_last)
				st_next = last_on_reg ? BSW_S0 : BSW_S5;
			else
				st_next = cfg_restore_on ? BSW_S0 : BSW_S5;
		end else if (st_reg == BSW_OFF) begin
			st_next = BSW_S5;
		end else if (long_next && !long_reg && st_reg != BSW_S5) begin
			st_next   = BSW_S5;
			pend_next = 7'h00;
		end else if (cmd_valid && cmd_code != BSW_CMD_NONE) begin
			unique case (cmd_code)
				BSW_CMD_S0: st_next = BSW_S0;
				BSW_CMD_S1: st_next = BSW_S1;
				BSW_CMD_S3: st_next = BSW_S3;
				BSW_CMD_S4: st_next = BSW_S4;
				BSW_CMD_S5: st_next = BSW_S5;
				default:    st_next = st_reg;
			endcase
		end else if (st_reg == BSW_S0) begin
			// short press in s0 asks software for sleep
			sreq_next = btn_rel && !long_reg;
			pend_next = 7'h00;
		end else if (pend_reg != 7'h00 && !(pend_reg == 7'h04 && wsync_reg[BSW_WK_BTN])) begin
			// button wake waits for release so a long hold can still force off
			st_next   = BSW_S0;
			pend_next = 7'h00;
		end

		if (ac_ok)
			last_on_next = (st_next == BSW_S0 || st_next == BSW_S1 || st_next == BSW_S3);
	end

	// registers only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg      <= BSW_S5;
			pend_reg    <= 7'h00;
			pr_reg      <= 27'h0;
			long_reg    <= 1'b0;
			last_on_reg <= BSW_LAST_ON_RST;
			ac_prev_reg <= 1'b1;
			deep_reg    <= BSW_DEEP_WAKE_RST;
			sreq_reg    <= 1'b0;
		end else begin
			st_reg      <= st_next;
			pend_reg    <= pend_next;
			pr_reg      <= pr_next;
			long_reg    <= long_next;
			last_on_reg <= last_on_next;
			ac_prev_reg <= ac_prev_next;
			deep_reg    <= deep_next;
			sreq_reg    <= sreq_next;
		end
	end

	// power and fan outputs decoded from the state register
	assign psu_on     = (st_reg == BSW_S0 || st_reg == BSW_S1);
	assign cpu_pwr_en = (st_reg == BSW_S0 || st_reg == BSW_S1);
	assign state_out  = st_reg;
	assign wake_pend  = pend_reg;
	assign btn_sleep_req = sreq_reg;

	assign fan_bus.run     = (st_reg == BSW_S0 || st_reg == BSW_S1);
	assign fan_bus.speed   = fan_speed;
	assign fan_bus.loop_en = fan_loop_en;

	bsw_fan_chan u_fan (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.ctl        (fan_bus.ctl),
		.tach       (fan_tach),
		.fan_pwm    (fan_pwm),
		.tach_count (fan_tach_count)
	);

endmodule : bsw_sleep_wake
`default_nettype wire
